//--- verilog/ssp_slave.sv
// Slave end of the byte-wide synchronous serial port
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module ssp_slave (
    input  wire logic       clk,       // System clock
    input  wire logic       rst_n,     // Asynchronous reset, active low
    ssp_link_if.slave       link,      // Serial link
    input  wire logic [3:0] addr,      // Register address
    input  wire logic [7:0] wdata,     // Write data
    input  wire logic       wr,        // Write strobe
    input  wire logic       rd,        // Read strobe
    output logic      [7:0] rdata,     // Read data, cycle after strobe
    output logic            irq,       // Interrupt level
    output logic            miso_o,    // Mirror of link data out
    output logic            miso_oe    // Mirror of link output enable
);
    typedef struct packed {
        logic [2:0] sck_s;    // sck sync, [2] is edge history
        logic [2:0] ss_s;     // select sync plus history
        logic [1:0] mosi_s;   // data sync
        logic [7:0] con1;
        logic [7:0] con3;
        logic [1:0] stat_hi;  // Sample phase and edge select
        logic       bf;
        logic [7:0] buf_q;
        logic [7:0] sr;
        logic [2:0] cnt;
        logic       busy;
        logic       dout;
        logic       oe;
        logic       irq_st;
        logic       irq_mask;
        logic [7:0] sel_clk;
        logic [7:0] sel_dat;
        logic [7:0] sel_ss;
        logic [7:0] rdata;
        logic       irq;
    } ssp_slv_state_t;

    ssp_slv_state_t s_reg, s_next;

    // Register read mux
    function automatic logic [7:0] rd_mux(input ssp_slv_state_t s, input logic [3:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == `SSP_OFF_BUF)           r = s.buf_q;
        else if (a == `SSP_OFF_CON1)     r = s.con1;
        else if (a == `SSP_OFF_CON3)     r = s.con3;
        else if (a == `SSP_OFF_STAT)     r = {s.stat_hi, 5'h00, s.bf};
        else if (a == `SSP_OFF_IRQ_STAT) r = {7'h00, s.irq_st};
        else if (a == `SSP_OFF_IRQ_MASK) r = {7'h00, s.irq_mask};
        else if (a == `SSP_OFF_PIN)      r = {5'h00, s.ss_s[1], s.mosi_s[1], s.sck_s[1]};
        else if (a == `SSP_OFF_CLK_SEL)  r = s.sel_clk;
        else if (a == `SSP_OFF_DAT_SEL)  r = s.sel_dat;
        else if (a == `SSP_OFF_SS_SEL)   r = s.sel_ss;
        return r;
    endfunction

    // Next-state logic
    always_comb
    begin
        logic en;
        logic ss_mode;
        logic sel;
        logic ck_rise;
        logic ck_fall;
        logic shift_e;
        logic sample_e;
        logic done;
        logic wr_ok;
        s_next = s_reg;
        en = 1'b0;
        ss_mode = 1'b0;
        sel = 1'b0;
        ck_rise = 1'b0;
        ck_fall = 1'b0;
        shift_e = 1'b0;
        sample_e = 1'b0;
        done = 1'b0;
        wr_ok = 1'b0;
        // Two-flop synchronisers; edges seen only from stage two onward
        s_next.sck_s  = {s_reg.sck_s[1:0], link.sck};
        s_next.ss_s   = {s_reg.ss_s[1:0], link.ss_n};
        s_next.mosi_s = {s_reg.mosi_s[0], link.mosi};
        en = s_reg.con1[`SSP_CON1_EN];
        ss_mode = (s_reg.con1[3:0] == `SSP_MODE_SLV_SS);
        sel = !ss_mode || !s_reg.ss_s[1];
        ck_rise = s_reg.sck_s[1] && !s_reg.sck_s[2];
        ck_fall = !s_reg.sck_s[1] && s_reg.sck_s[2];
        // Idle-to-active edge samples unless edge select flips it
        if (s_reg.con1[`SSP_CON1_CKP] ^ s_reg.stat_hi[0])
        begin
            sample_e = ck_fall;
            shift_e  = ck_rise;
        end
        else
        begin
            sample_e = ck_rise;
            shift_e  = ck_fall;
        end
        // Sample in, then shift on the opposite edge; MSB out first
        if (en && sel && sample_e)
        begin
            s_next.sr = {s_reg.sr[6:0], s_reg.mosi_s[1]};
            s_next.cnt = s_reg.cnt + 3'd1;
            s_next.busy = 1'b1;
            done = (s_reg.cnt == 3'd7);
        end
        if (en && sel && shift_e)
            s_next.dout = s_reg.sr[7];
        // Byte complete: received byte becomes next transmit byte too
        if (done)
        begin
            s_next.buf_q = {s_reg.sr[6:0], s_reg.mosi_s[1]};
            s_next.busy = 1'b0;
            if (s_reg.bf)
                s_next.con1[`SSP_CON1_OV] = 1'b1;
            s_next.bf = 1'b1;
            s_next.irq_st = 1'b1;
        end
        // Deselect or disable resets the counter
        if (!en || (ss_mode && s_reg.ss_s[1]))
        begin
            s_next.cnt = 3'd0;
            s_next.busy = 1'b0;
        end
        // Falling select realigns bit position and preloads output
        if (ss_mode && !s_reg.ss_s[1] && s_reg.ss_s[2])
        begin
            s_next.cnt = 3'd0;
            s_next.dout = s_reg.sr[7];
        end
        s_next.oe = en && sel && (s_reg.con1[3:0] != 4'h0);
        // Software writes
        if (s_reg.busy)
            wr_ok = 1'b0;
        else
            wr_ok = !s_reg.con1[`SSP_CON1_WRITE_COLLISION] &&
                    (!s_reg.bf || s_reg.con3[`SSP_CON3_BUFFER_OVERWRITE_ENABLE]);
        if (wr)
        begin
            if (addr == `SSP_OFF_BUF)
            begin
                if (wr_ok && !done)
                begin
                    s_next.buf_q = wdata;
                    s_next.sr = wdata;
                    s_next.dout = wdata[7];
                end
                else if (s_reg.busy || done)
                    s_next.con1[`SSP_CON1_WRITE_COLLISION] = 1'b1;
            end
            else if (addr == `SSP_OFF_CON1)
                s_next.con1 = {wdata[7] & s_reg.con1[7],
                               (wdata[6] & s_reg.con1[6]) | (done & s_reg.bf), wdata[5:0]};
            else if (addr == `SSP_OFF_CON3)
                s_next.con3 = wdata;
            else if (addr == `SSP_OFF_STAT)
                s_next.stat_hi = wdata[7:6];
            else if (addr == `SSP_OFF_IRQ_STAT)
                s_next.irq_st = s_reg.irq_st & ~wdata[0] | done;         // Set wins
            else if (addr == `SSP_OFF_IRQ_MASK)
                s_next.irq_mask = wdata[0];
            else if (addr == `SSP_OFF_CLK_SEL)
                s_next.sel_clk = wdata;
            else if (addr == `SSP_OFF_DAT_SEL)
                s_next.sel_dat = wdata;
            else if (addr == `SSP_OFF_SS_SEL)
                s_next.sel_ss = wdata;
        end
        // Reading the buffer clears full, unless a byte lands now
        if (rd && addr == `SSP_OFF_BUF && !done)
            s_next.bf = 1'b0;
        s_next.rdata = rd ? rd_mux(s_reg, addr) : 8'h00;
        s_next.irq = s_next.irq_st && s_next.irq_mask;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg      <= '0;
            s_reg.ss_s <= 3'b111; // Select idles high, so no false edge after reset
        end
        else
            s_reg <= s_next;
    end

    assign rdata   = s_reg.rdata;
    assign irq     = s_reg.irq;
    assign miso_o  = s_reg.dout;
    assign miso_oe = s_reg.oe;
    assign link.miso_o  = s_reg.dout;
    assign link.miso_oe = s_reg.oe;
endmodule
`default_nettype wire

//--- verilog/ssp_params.svh
// Constants for the serial slave port and its bus master end
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// Register offsets (software port)
`define SSP_OFF_BUF        4'h0
`define SSP_OFF_CON1       4'h1
`define SSP_OFF_CON3       4'h2
`define SSP_OFF_STAT       4'h3
`define SSP_OFF_IRQ_STAT   4'h4
`define SSP_OFF_IRQ_MASK   4'h5
`define SSP_OFF_PIN        4'h6
`define SSP_OFF_CLK_SEL    4'h7
`define SSP_OFF_DAT_SEL    4'h8
`define SSP_OFF_SS_SEL     4'h9
// Host-side offsets
`define SSPM_OFF_TXD       4'h0
`define SSPM_OFF_CTRL      4'h1
`define SSPM_OFF_RXD       4'h2
`define SSPM_OFF_STAT      4'h3
`define SSPM_OFF_IRQ_STAT  4'h4
`define SSPM_OFF_IRQ_MASK  4'h5
// Control one fields
`define SSP_CON1_WRITE_COLLISION      7
`define SSP_CON1_OV        6
`define SSP_CON1_EN        5
`define SSP_CON1_CKP       4
// Control three fields
`define SSP_CON3_BUFFER_OVERWRITE_ENABLE      4
// Status fields
`define SSP_STAT_SMP       7
`define SSP_STAT_CKE       6
`define SSP_STAT_BF        0
// Mode codes
`define SSP_MODE_SLV_SS    4'h4
`define SSP_MODE_SLV_NOSS  4'h5
// Reset values
`define SSP_RST_BYTE       8'h00
`define SSP_PIN_SEL_RST    8'h00
// Host serial clock: half period in system clocks
`define SSPM_HALF_DIV      8'h04
`endif

//--- verilog/ssp_pkg.sv
// Types used by the bus master end of the serial port
package ssp_pkg;
    typedef enum logic [1:0] {
        SSPM_IDLE  = 2'b00,
        SSPM_LEAD  = 2'b01,
        SSPM_TRAIL = 2'b11,
        SSPM_DONE  = 2'b10
    } ssp_mst_state_t;
endpackage

//--- verilog/ssp_link_if.sv
// Serial link between the bus master end and the slave port
`timescale 1ns/1ps
`default_nettype none
interface ssp_link_if;
    logic sck;      // Serial clock, made by the master
    logic ss_n;     // Slave select, active low
    logic mosi;     // Master to slave data
    logic miso_o;   // Slave data out
    logic miso_oe;  // Slave drives data out
    logic miso;     // Resolved line level
    assign miso = miso_oe ? miso_o : 1'b0;
    modport master (output sck, output ss_n, output mosi, input miso);
    modport slave  (input sck, input ss_n, input mosi, output miso_o, output miso_oe);
endinterface
`default_nettype wire

//--- verilog/ssp_master.sv
// Bus master end that drives the serial link
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module ssp_master (
    input  wire logic       clk,    // System clock
    input  wire logic       rst_n,  // Asynchronous reset, active low
    ssp_link_if.master      link,   // Serial link
    input  wire logic [3:0] addr,   // Register address
    input  wire logic [7:0] wdata,  // Write data
    input  wire logic       wr,     // Write strobe
    input  wire logic       rd,     // Read strobe
    output logic      [7:0] rdata,  // Read data, cycle after strobe
    output logic            irq     // Interrupt level
);
    typedef struct packed {
        ssp_pkg::ssp_mst_state_t st;
        logic [7:0] div;
        logic [2:0] cnt;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [2:0] ctrl;     // [0] polarity, [1] stored and read back but unused, [2] hold select
        logic [1:0] miso_s;
        logic       sck;
        logic       ss_n;
        logic       mosi;
        logic       irq_st;
        logic       irq_mask;
        logic [7:0] rdata;
        logic       irq;
    } ssp_mst_reg_t;

    ssp_mst_reg_t m_reg, m_next;

    // Sequencer: lead half drives data, trail half samples it
    always_comb
    begin
        logic tick;
        m_next = m_reg;
        tick = (m_reg.div == 8'h00);
        m_next.miso_s = {m_reg.miso_s[0], link.miso};
        m_next.div = tick ? (`SSPM_HALF_DIV - 8'h01) : (m_reg.div - 8'h01);
        if (m_reg.st == ssp_pkg::SSPM_IDLE)
        begin
            m_next.sck = m_reg.ctrl[0];
            m_next.div = `SSPM_HALF_DIV - 8'h01;
        end
        case (m_reg.st)
            ssp_pkg::SSPM_IDLE: ;
            ssp_pkg::SSPM_LEAD:
                if (tick)
                begin
                    m_next.sck = ~m_reg.sck;
                    m_next.st = ssp_pkg::SSPM_TRAIL;
                end
            ssp_pkg::SSPM_TRAIL:
                if (tick)
                begin
                    m_next.sck = ~m_reg.sck;
                    m_next.tx = {m_reg.tx[6:0], 1'b0};
                    // Slave data needs two sync stages each way, longer than a lead half
                    m_next.rx = {m_reg.rx[6:0], m_reg.miso_s[1]};
                    m_next.mosi = m_reg.tx[6];
                    m_next.cnt = m_reg.cnt + 3'd1;
                    m_next.st = (m_reg.cnt == 3'd7) ? ssp_pkg::SSPM_DONE : ssp_pkg::SSPM_LEAD;
                end
            ssp_pkg::SSPM_DONE:
            begin
                m_next.ss_n = m_reg.ctrl[2] ? 1'b0 : 1'b1;
                m_next.irq_st = 1'b1;
                m_next.st = ssp_pkg::SSPM_IDLE;
            end
            default: m_next.st = ssp_pkg::SSPM_IDLE;
        endcase
        if (wr)
        begin
            if (addr == `SSPM_OFF_TXD && m_reg.st == ssp_pkg::SSPM_IDLE)
            begin
                m_next.tx = wdata;
                m_next.mosi = wdata[7];
                m_next.ss_n = 1'b0;
                m_next.cnt = 3'd0;
                m_next.st = ssp_pkg::SSPM_LEAD;
            end
            else if (addr == `SSPM_OFF_CTRL)
            begin
                m_next.ctrl = wdata[2:0];
                if (!wdata[2] && m_reg.st == ssp_pkg::SSPM_IDLE)
                    m_next.ss_n = 1'b1;
            end
            else if (addr == `SSPM_OFF_IRQ_STAT)
                m_next.irq_st = (m_reg.irq_st & ~wdata[0]) | m_next.irq_st & (m_reg.st == ssp_pkg::SSPM_DONE);
            else if (addr == `SSPM_OFF_IRQ_MASK)
                m_next.irq_mask = wdata[0];
        end
        m_next.rdata = 8'h00;
        if (rd)
        begin
            if (addr == `SSPM_OFF_RXD)           m_next.rdata = m_reg.rx;
            else if (addr == `SSPM_OFF_CTRL)     m_next.rdata = {5'h00, m_reg.ctrl};
            else if (addr == `SSPM_OFF_STAT)     m_next.rdata = {7'h00, m_reg.st != ssp_pkg::SSPM_IDLE};
            else if (addr == `SSPM_OFF_IRQ_STAT) m_next.rdata = {7'h00, m_reg.irq_st};
            else if (addr == `SSPM_OFF_IRQ_MASK) m_next.rdata = {7'h00, m_reg.irq_mask};
        end
        m_next.irq = m_next.irq_st && m_next.irq_mask;
    end

    // State register; select idles high, a stopped clock holds a transfer in place
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            m_reg <= '0;
            m_reg.ss_n <= 1'b1;
        end
        else
            m_reg <= m_next;
    end

    assign link.sck  = m_reg.sck;
    assign link.ss_n = m_reg.ss_n;
    assign link.mosi = m_reg.mosi;
    assign rdata = m_reg.rdata;
    assign irq   = m_reg.irq;
endmodule
`default_nettype wire

//--- dv/ssp_link_properties.sv
// Link properties for the serial port pair
`timescale 1ns/1ps
`default_nettype none
module ssp_link_properties (
    input wire logic clk,     // System clock
    input wire logic rst_n,   // Reset, active low
    input wire logic sck,     // Serial clock
    input wire logic ss_n,    // Slave select
    input wire logic mosi,    // Master data
    input wire logic miso_oe  // Slave drives data
);
    logic       sck_d;
    logic       idle_lvl;
    logic [3:0] tog_cnt;
    wire  logic tog;
    // Clock toggle as seen by the system clock
    assign tog = sck != sck_d;
    // Idle level is learnt between frames, so a polarity change needs no extra port
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            sck_d    <= 1'b0;
            idle_lvl <= 1'b0;
            tog_cnt  <= 4'h0;
        end
        else
        begin
            sck_d    <= sck;
            idle_lvl <= ss_n ? sck : idle_lvl;
            tog_cnt  <= ss_n ? 4'h0 : tog_cnt + {3'h0, tog};
        end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_deselect;
        $rose(ss_n);
    endsequence
    sequence s_released;
        !miso_oe [*3];
    endsequence
    a_reset_lines_idle: assert property ($rose(rst_n) |-> ss_n && !miso_oe)
        else $error("link not idle after reset");
    a_release_prompt: assert property (s_deselect |-> ##[0:5] s_released)
        else $error("data output still driven after deselect");
    a_deselect_quiet: assert property (ss_n [*5] |-> !miso_oe)
        else $error("data output driven while deselected");
    a_half_period_min: assert property (tog |=> !tog [*3])
        else $error("serial clock half period too short");
    a_bytes_whole: assert property (s_deselect |-> (tog_cnt + {3'h0, tog}) == 4'h0)
        else $error("frame did not carry whole bytes");
    a_idle_at_end: assert property (s_deselect |-> sck == idle_lvl)
        else $error("serial clock not at idle level at frame end");
    a_mosi_held_sample: assert property ((!ss_n && tog && sck != idle_lvl) |-> $stable(mosi))
        else $error("master data moved on the sampling edge");
    a_clock_after_select: assert property ($fell(ss_n) |-> ##[1:12] tog)
        else $error("no clock after select");
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the serial master and slave pair
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"
module testbench;
    logic       clk = 1'b0;
    logic       rst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       m_wr;
    logic       m_rd;
    logic       s_wr;
    logic       s_rd;
    logic [7:0] m_rdata;
    logic [7:0] s_rdata;
    logic       m_irq;
    logic       s_irq;
    logic       s_miso_o;
    logic       s_miso_oe;
    logic [7:0] rx;
    int         mismatches = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    ssp_link_if link_i ();
    ssp_master ssp_master_i (.clk(clk), .rst_n(rst_n), .link(link_i), .addr(addr), .wdata(wdata),
        .wr(m_wr), .rd(m_rd), .rdata(m_rdata), .irq(m_irq));
    ssp_slave ssp_slave_i (.clk(clk), .rst_n(rst_n), .link(link_i), .addr(addr), .wdata(wdata),
        .wr(s_wr), .rd(s_rd), .rdata(s_rdata), .irq(s_irq), .miso_o(s_miso_o), .miso_oe(s_miso_oe));
    ssp_link_properties ssp_link_properties_i (.clk(clk), .rst_n(rst_n), .sck(link_i.sck),
        .ss_n(link_i.ss_n), .mosi(link_i.mosi), .miso_oe(link_i.miso_oe));
    initial
        forever #10 clk = ~clk;
    // Cut a hang short well past the longest expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    // Both register ports share address and data; only the strobes differ
    task automatic bus_wr(input logic sl, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        s_wr  <= sl;
        m_wr  <= !sl;
        @(posedge clk);
        s_wr  <= 1'b0;
        m_wr  <= 1'b0;
    endtask
    task automatic bus_rd(input logic sl, input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        s_rd <= sl;
        m_rd <= !sl;
        @(posedge clk);
        s_rd <= 1'b0;
        m_rd <= 1'b0;
        @(negedge clk);
        d = sl ? s_rdata : m_rdata;
    endtask
    task automatic rd_chk(input logic sl, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bus_rd(sl, a, d);
        check($sformatf("register %h of side %b", a, sl), exp, d);
    endtask
    // Slave flags land before the master finishes unless edge select is set, then a few cycles after; hence the settle time
    task automatic finish(output logic [7:0] d);
        for (int n = 0; n < 400 && m_irq !== 1'b1; n++)
            @(posedge clk);
        check("master done", 8'h01, {7'h00, m_irq});
        repeat (8) @(posedge clk);
        bus_wr(1'b0, `SSPM_OFF_IRQ_STAT, 8'h01);
        bus_rd(1'b0, `SSPM_OFF_RXD, d);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic [7:0] exp);
        bus_wr(1'b0, `SSPM_OFF_TXD, tx);
        finish(rx);
        check("master rx", exp, rx);
    endtask
    task automatic t_reset_values;
        for (int a = 0; a < 10; a++)
            rd_chk(1'b1, 4'(a), (a == 6) ? 8'h04 : 8'h00);
        rd_chk(1'b1, 4'hf, 8'h00);
        rd_chk(1'b0, `SSPM_OFF_RXD, 8'h00);
    endtask
    task automatic t_exchange(input logic pol);
        logic [7:0] tx;
        tx = 8'ha5 ^ {8{pol}};
        bus_wr(1'b1, `SSP_OFF_CON1, 8'h00);
        bus_wr(1'b0, `SSPM_OFF_CTRL, {7'h00, pol});
        // Let the new idle level pass the master register and the pin synchronisers
        repeat (4) @(posedge clk);
        rd_chk(1'b1, `SSP_OFF_PIN, {7'h02, pol});
        bus_wr(1'b1, `SSP_OFF_CON1, {3'b001, pol, 4'h4});
        bus_wr(1'b1, `SSP_OFF_STAT, 8'h00);
        bus_wr(1'b1, `SSP_OFF_IRQ_MASK, {7'h00, !pol});
        bus_wr(1'b1, `SSP_OFF_BUF, tx);
        @(negedge clk);
        check("miso data", {7'h00, tx[7]}, {7'h00, s_miso_o});
        xfer(8'h3c, tx);
        check("slave irq", {7'h00, !pol}, {7'h00, s_irq});
        rd_chk(1'b1, `SSP_OFF_IRQ_STAT, 8'h01);
        rd_chk(1'b1, `SSP_OFF_STAT, 8'h01);
        rd_chk(1'b1, `SSP_OFF_BUF, 8'h3c);
        rd_chk(1'b1, `SSP_OFF_STAT, 8'h00);
        bus_wr(1'b1, `SSP_OFF_IRQ_STAT, 8'h01);
        repeat (2) @(negedge clk);
        check("slave irq", 8'h00, {7'h00, s_irq});
    endtask
    task automatic t_collision;
        bus_wr(1'b1, `SSP_OFF_CON1, 8'h00);
        bus_wr(1'b0, `SSPM_OFF_CTRL, 8'h00);
        bus_wr(1'b1, `SSP_OFF_CON1, 8'h24);
        bus_wr(1'b1, `SSP_OFF_BUF, 8'h69);
        bus_wr(1'b0, `SSPM_OFF_TXD, 8'h81);
        repeat (20) @(posedge clk);
        check("miso enable", 8'h01, {7'h00, s_miso_oe});
        bus_wr(1'b1, `SSP_OFF_BUF, 8'hee);
        rd_chk(1'b1, `SSP_OFF_CON1, 8'ha4);
        finish(rx);
        check("master rx", 8'h69, rx);
        rd_chk(1'b1, `SSP_OFF_BUF, 8'h81);
        bus_wr(1'b1, `SSP_OFF_BUF, 8'h55);
        xfer(8'h00, 8'h81);
        bus_wr(1'b1, `SSP_OFF_CON1, 8'h24);
        rd_chk(1'b1, `SSP_OFF_CON1, 8'h24);
    endtask
    // Unread bytes are echoed out on the next burst
    task automatic t_daisy;
        rd_chk(1'b1, `SSP_OFF_BUF, 8'h00);
        xfer(8'h5a, 8'h00);
        xfer(8'h00, 8'h5a);
        rd_chk(1'b1, `SSP_OFF_CON1, 8'h64);
        bus_wr(1'b1, `SSP_OFF_BUF, 8'h77);
        xfer(8'hc0, 8'h00);
        bus_wr(1'b1, `SSP_OFF_CON3, 8'h10);
        bus_wr(1'b1, `SSP_OFF_BUF, 8'h77);
        xfer(8'h00, 8'h77);
    endtask
    task automatic t_disable;
        bus_wr(1'b1, `SSP_OFF_CON1, 8'h24);
        rd_chk(1'b1, `SSP_OFF_CON1, 8'h24);
        bus_rd(1'b1, `SSP_OFF_BUF, rx);
        bus_wr(1'b1, `SSP_OFF_BUF, 8'hc3);
        bus_wr(1'b0, `SSPM_OFF_TXD, 8'h11);
        repeat (24) @(posedge clk);
        bus_wr(1'b1, `SSP_OFF_CON1, 8'h04);
        repeat (6) @(posedge clk);
        check("miso enable", 8'h00, {7'h00, s_miso_oe});
        finish(rx);
        bus_wr(1'b1, `SSP_OFF_CON1, 8'h24);
        bus_wr(1'b1, `SSP_OFF_BUF, 8'h96);
        xfer(8'h22, 8'h96);
        rd_chk(1'b1, `SSP_OFF_BUF, 8'h22);
    endtask
    task automatic t_mode_off;
        bus_wr(1'b1, `SSP_OFF_CON1, 8'h20);
        bus_wr(1'b0, `SSPM_OFF_TXD, 8'h00);
        repeat (30) @(posedge clk);
        check("miso enable", 8'h00, {7'h00, s_miso_oe});
        finish(rx);
        check("master rx", 8'h00, rx);
    endtask
    initial
    begin
        rst_n = 1'b0;
        addr  = 4'h0;
        wdata = 8'h00;
        m_wr  = 1'b0;
        m_rd  = 1'b0;
        s_wr  = 1'b0;
        s_rd  = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bus_wr(1'b0, `SSPM_OFF_IRQ_MASK, 8'h01);
        t_reset_values();
        t_exchange(1'b0);
        t_exchange(1'b1);
        t_collision();
        t_daisy();
        t_disable();
        t_mode_off();
        end_of_test();
    end
endmodule
`default_nettype wire
